// *** verilog/stcmd_defines.svh ***
// constants for the start-up timing and input undervoltage warning block
// Operation
// - undervoltage warning limit uses word read/write
// - each phase detects its own warning; here one compare of input supply telemetry
// - warning sets summary, input and warning flags
// - linear words, five-bit exponent, eleven-bit mantissa
// - warning limit defaults 2.5 V, programmable 5-22 V
// - no reprogramming below 5 V once above
// - out-of-range writes flag invalid data, notify
// - delay runs from start until rise begins
// - about 100 us minimum delay after power-on
// - delay accepts 0-127.5 ms, half-ms steps
// - restored delay snaps to nearest supported value
// - rise time sets reference ramp duration
// - rise 0-31.75 ms, quarter steps, min 0.5
// - rise loads from memory or strap pins
// - timeout bounds time from delay end to 85%
// - output undervoltage checking starts after rise
// - timeout limit accepts 0-127 ms, half steps
// - at expiry compare telemetry with 87.5 percent
// - last telemetry sample may lag up to 2 ms
// - zero timeout limit disables timeout detection
// - timeout response codes ignore, delayed, immediate shutdown
// - timeout sets output summary and timeout flags
`ifndef STCMD_DEFINES_SVH
`define STCMD_DEFINES_SVH
`define CMD_UV_WARN 8'h58
`define CMD_ON_DELAY 8'h60
`define CMD_RISE 8'h61
`define CMD_TMO 8'h62
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define EXP_UV 5'h1E
`define EXP_DLY 5'h1F
`define EXP_RISE 5'h1E
`define EXP_TMO 5'h1F
`define UV_DEF_MAN 11'h00A
`define LIN_FRAC 8
`define UV_MIN 32'sh00000500
`define UV_MAX 32'sh00001600
`define DLY_MAX 32'sh00007F80
`define RISE_MAX 32'sh00001FC0
`define TMO_MAX 32'sh00007F00
`define RISE_MIN_Q 7'h02
`define CLK_MHZ 100
`define TICK_US 250
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`define INIT_US 100
`define INIT_CYC (`INIT_US * `CLK_MHZ)
`define RESP_IGNORE 2'h0
`define RESP_DELAYED 2'h1
`define LOAD_WAIT 2'h3
`define ST_NOTA 0
`define ST_INPUT 1
`define ST_VOUT 2
`define ST_UVW 3
`define ST_TONMAX 4
`define ST_CML_DATA 5
`define ST_CML_CMD 6
`define ST_CML 7
`endif

// *** verilog/stcmd_pkg.sv ***
// types shared by the start-up timing block
package stcmd_pkg;
  typedef enum logic [5:0] {
    S_OFF = 6'h01,
    S_DELAY = 6'h02,
    S_RISE = 6'h04,
    S_ON = 6'h08,
    S_FWAIT = 6'h10,
    S_SHUT = 6'h20
  } stcmd_state_t;
  typedef logic [15:0] stcmd_word_t;
endpackage: stcmd_pkg

// *** verilog/stcmd_xfer_if.sv ***
// command handshake between link domain and core domain
`timescale 1ns/1ps
`default_nettype none
interface stcmd_xfer_if;
  logic req_tgl;
  logic ack_tgl;
  logic wr;
  logic [7:0] code;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport link (output req_tgl, output wr, output code, output wdata, input ack_tgl, input rdata);
  modport core (input req_tgl, input wr, input code, input wdata, output ack_tgl, output rdata);
endinterface: stcmd_xfer_if
`default_nettype wire

// *** verilog/stcmd_tick.sv ***
// quarter-millisecond time base
`timescale 1ns/1ps
`default_nettype none
`include "stcmd_defines.svh"
module stcmd_tick #(
  parameter int CYC = `TICK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  output logic tick
);
  logic [15:0] cnt_r;
  wire wrap = cnt_r == 16'(CYC - 1);
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
      tick <= wrap;
    end
  end
endmodule: stcmd_tick
`default_nettype wire

// *** verilog/stcmd_link.sv ***
// link-clock command port, toggle handshake toward the core
`timescale 1ns/1ps
`default_nettype none
module stcmd_link (
  input wire logic lclk,
  input wire logic lrst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  stcmd_xfer_if.link xf
);
  logic busy_r, req_r, ack_m_r, ack_s_r, ack_seen_r, wr_r;
  logic [7:0] code_r;
  logic [15:0] wdata_r;
  wire take = cmd_valid && !busy_r;
  wire done = busy_r && (ack_s_r != ack_seen_r);
  assign cmd_ready = !busy_r;
  // held fields stay still until the ack returns, so the core may read them directly
  assign xf.req_tgl = req_r;
  assign xf.wr = wr_r;
  assign xf.code = code_r;
  assign xf.wdata = wdata_r;
  always_ff @(posedge lclk)
  begin
    if (lrst)
    begin
      busy_r <= 1'b0;
      req_r <= 1'b0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      ack_seen_r <= 1'b0;
      wr_r <= 1'b0;
      code_r <= 8'h00;
      wdata_r <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      ack_m_r <= xf.ack_tgl;
      ack_s_r <= ack_m_r;
      rsp_valid <= done;
      if (take)
      begin
        wr_r <= cmd_write;
        code_r <= cmd_code;
        wdata_r <= cmd_wdata;
        req_r <= ~req_r;
        busy_r <= 1'b1;
      end
      else if (done)
      begin
        ack_seen_r <= ack_s_r;
        rsp_data <= xf.rdata;
        busy_r <= 1'b0;
      end
    end
  end
endmodule: stcmd_link
`default_nettype wire

// *** verilog/stcmd_top.sv ***
// start-up timing, turn-on timeout and input undervoltage warning commands
`timescale 1ns/1ps
`default_nettype none
`include "stcmd_defines.svh"
module stcmd_top
  import stcmd_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYC,
  parameter int INIT_CYCLES = `INIT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clock,
  input wire logic link_rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic on_start_pin,
  input wire logic strap_rise_sel_pin,
  input wire logic [6:0] strap_rise_pin,
  input wire logic nvm_valid,
  input wire logic [10:0] nvm_uv_man,
  input wire logic [10:0] nvm_dly_man,
  input wire logic [10:0] nvm_rise_man,
  input wire logic [10:0] nvm_tmo_man,
  input wire logic [15:0] power_input_supply_tlm,
  input wire logic power_input_supply_valid,
  input wire logic [15:0] vout_tlm,
  input wire logic vout_tlm_valid,
  input wire logic [15:0] vout_cmd,
  input wire logic [1:0] timeout_response_code,
  input wire logic [2:0] timeout_delay_ms,
  input wire logic clear_faults,
  output logic input_uv_warning_flag,
  output logic status_input_summary,
  output logic status_vout_summary,
  output logic status_none_above,
  output logic status_cml_summary,
  output logic status_ton_max,
  output logic status_cml_data,
  output logic status_cml_cmd,
  output logic alert_n,
  output logic power_stage_en,
  output logic ref_ramp_en,
  output logic [6:0] rise_quarters,
  output logic uv_check_en,
  output logic ton_max_fault
);
  function automatic logic signed [31:0] lin_scaled(input logic [15:0] w);
    logic signed [31:0] mv;
    int sh;
    mv = 32'(signed'(w[`MAN_MSB:0]));
    sh = int'(signed'(w[`EXP_MSB:`EXP_LSB])) + `LIN_FRAC;
    if (sh > 20)
      lin_scaled = 32'sh7FFFFFFF;
    else if (sh >= 0)
      lin_scaled = mv <<< sh;
    else
      lin_scaled = mv >>> (-sh);
  endfunction: lin_scaled

  function automatic logic [7:0] clip8(input logic signed [31:0] v);
    if (v < 0)
      clip8 = 8'h00;
    else if (v > 32'sd255)
      clip8 = 8'hFF;
    else
      clip8 = v[7:0];
  endfunction: clip8

  stcmd_xfer_if xf();
  logic tick;
  stcmd_link u_link (
    .lclk(link_clock),
    .lrst(link_rst),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .xf(xf.link)
  );
  stcmd_tick #(.CYC(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  logic [8:0] pin_m_r, pin_s_r;
  logic req_m_r, req_s_r, req_seen_r, ack_r;
  logic [15:0] rdata_r, uv_w_r, dly_w_r, rise_w_r, tmo_w_r, uv_lim_r;
  logic [15:0] vin_last_r, vout_last_r;
  logic [7:0] dly_h_r, tmo_h_r;
  logic [6:0] rise_q_r;
  logic [1:0] load_cnt_r;
  logic loaded_r, init_done_r, tmo_run_r;
  logic [13:0] init_cnt_r;
  logic [9:0] ph_cnt_r, tmo_cnt_r;
  logic [7:0] st_r;
  stcmd_state_t state_r, state_nxt;

  wire start_s = pin_s_r[0];
  wire strap_sel_s = pin_s_r[1];
  wire [6:0] strap_q_s = pin_s_r[8:2];
  wire req_evt = req_s_r != req_seen_r;
  wire hit_uv = xf.code == `CMD_UV_WARN;
  wire hit_dly = xf.code == `CMD_ON_DELAY;
  wire hit_rise = xf.code == `CMD_RISE;
  wire hit_tmo = xf.code == `CMD_TMO;
  wire hit_any = hit_uv || hit_dly || hit_rise || hit_tmo;
  wire signed [31:0] wv = lin_scaled(xf.wdata);
  wire uv_ok = (wv >= `UV_MIN) && (wv <= `UV_MAX);
  wire dly_ok = (wv >= 0) && (wv <= `DLY_MAX) && (wv[6:0] == 7'h00);
  wire rise_ok = (wv >= 0) && (wv <= `RISE_MAX) && (wv[5:0] == 6'h00);
  wire tmo_ok = (wv >= 0) && (wv <= `TMO_MAX) && (wv[6:0] == 7'h00);
  wire wr_ok = hit_uv ? uv_ok : hit_dly ? dly_ok : hit_rise ? rise_ok : tmo_ok;
  wire wr_evt = req_evt && xf.wr && hit_any && wr_ok;
  wire bad_data = req_evt && xf.wr && hit_any && !wr_ok;
  wire bad_cmd = req_evt && !hit_any;
  wire [15:0] rdata_nxt = hit_uv ? uv_w_r : hit_dly ? dly_w_r : hit_rise ? rise_w_r : hit_tmo ? tmo_w_r : 16'h0000;
  assign xf.ack_tgl = ack_r;
  assign xf.rdata = rdata_r;

  // load waits for the strap synchronisers to settle
  wire load_evt = !loaded_r && (load_cnt_r == `LOAD_WAIT);
  wire [10:0] uv_ld_man = nvm_valid ? nvm_uv_man : `UV_DEF_MAN;
  wire signed [31:0] dly_nv = lin_scaled({`EXP_DLY, nvm_valid ? nvm_dly_man : 11'h000});
  wire signed [31:0] rise_nv = lin_scaled({`EXP_RISE, nvm_valid ? nvm_rise_man : 11'h000});
  wire signed [31:0] tmo_nv = lin_scaled({`EXP_TMO, nvm_valid ? nvm_tmo_man : 11'h000});
  wire [7:0] dly_ld = clip8((dly_nv + 32'sd64) >>> 7);
  wire [7:0] tmo_ld = clip8(tmo_nv >>> 7);
  wire [7:0] rise_nq = clip8(rise_nv >>> 6);
  wire [6:0] rise_ld = strap_sel_s ? strap_q_s : (rise_nq[7] ? 7'h7F : rise_nq[6:0]);
  wire [6:0] rise_eff = (rise_q_r < `RISE_MIN_Q) ? `RISE_MIN_Q : rise_q_r;

  wire uv_evt = loaded_r && (vin_last_r < uv_lim_r);
  wire [15:0] thr875 = vout_cmd - {3'h0, vout_cmd[15:3]};
  wire [31:0] p85 = (32'(vout_cmd) * 32'd17) / 32'd20;
  wire reached = vout_last_r >= p85[15:0];
  wire short875 = vout_last_r < thr875;
  wire [9:0] dly_ticks = {1'b0, dly_h_r, 1'b0};
  wire [9:0] rise_ticks = {3'h0, rise_eff};
  wire [9:0] tmo_ticks = {1'b0, tmo_h_r, 1'b0};
  wire [9:0] fdly_ticks = {5'h00, timeout_delay_ms, 2'h0};
  wire tmo_expire = tmo_run_r && tick && (tmo_ticks != 10'h000) && (tmo_cnt_r == tmo_ticks - 10'h001);
  wire tmo_evt = tmo_expire && short875;
  wire rise_start = (state_r == S_DELAY) && (state_nxt == S_RISE);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      S_OFF:
        if (start_s && loaded_r)
          state_nxt = S_DELAY;
      S_DELAY:
        if (!start_s)
          state_nxt = S_OFF;
        else if (init_done_r && (ph_cnt_r >= dly_ticks))
          state_nxt = S_RISE;
      S_RISE:
        if (!start_s)
          state_nxt = S_OFF;
        else if (ph_cnt_r >= rise_ticks)
          state_nxt = S_ON;
      S_ON:
        if (!start_s)
          state_nxt = S_OFF;
      S_FWAIT:
        if (!start_s)
          state_nxt = S_OFF;
        else if (ph_cnt_r >= fdly_ticks)
          state_nxt = short875 ? S_SHUT : S_ON;
      S_SHUT:
        if (!start_s)
          state_nxt = S_OFF;
      default:
        state_nxt = S_OFF;
    endcase
    if (tmo_evt && start_s && (timeout_response_code != `RESP_IGNORE))
      state_nxt = (timeout_response_code == `RESP_DELAYED) ? S_FWAIT : S_SHUT;
  end

  wire [7:0] st_set = {bad_data | bad_cmd, bad_cmd, bad_data, tmo_evt, uv_evt, tmo_evt, uv_evt, uv_evt | tmo_evt};
  // an event in the clearing cycle survives
  wire [7:0] st_nxt = st_set | (st_r & {8{~clear_faults}});
  assign status_none_above = st_r[`ST_NOTA];
  assign status_input_summary = st_r[`ST_INPUT];
  assign status_vout_summary = st_r[`ST_VOUT];
  assign input_uv_warning_flag = st_r[`ST_UVW];
  assign status_ton_max = st_r[`ST_TONMAX];
  assign status_cml_data = st_r[`ST_CML_DATA];
  assign status_cml_cmd = st_r[`ST_CML_CMD];
  assign status_cml_summary = st_r[`ST_CML];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_m_r <= 9'h000;
      pin_s_r <= 9'h000;
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      req_seen_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      pin_m_r <= {strap_rise_pin, strap_rise_sel_pin, on_start_pin};
      pin_s_r <= pin_m_r;
      req_m_r <= xf.req_tgl;
      req_s_r <= req_m_r;
      req_seen_r <= req_s_r;
      if (req_evt)
      begin
        rdata_r <= xf.wr ? xf.wdata : rdata_nxt;
        ack_r <= ~ack_r;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      load_cnt_r <= 2'h0;
      loaded_r <= 1'b0;
      uv_w_r <= 16'h0000;
      dly_w_r <= 16'h0000;
      rise_w_r <= 16'h0000;
      tmo_w_r <= 16'h0000;
      uv_lim_r <= 16'h0000;
      dly_h_r <= 8'h00;
      rise_q_r <= 7'h00;
      tmo_h_r <= 8'h00;
    end
    else if (load_evt)
    begin
      loaded_r <= 1'b1;
      uv_w_r <= {`EXP_UV, uv_ld_man};
      uv_lim_r <= lin_scaled({`EXP_UV, uv_ld_man}) >= 0 ? 16'(lin_scaled({`EXP_UV, uv_ld_man})) : 16'h0000;
      dly_w_r <= {`EXP_DLY, 3'h0, dly_ld};
      dly_h_r <= dly_ld;
      rise_w_r <= {`EXP_RISE, 4'h0, rise_ld};
      rise_q_r <= rise_ld;
      tmo_w_r <= {`EXP_TMO, 3'h0, tmo_ld};
      tmo_h_r <= tmo_ld;
    end
    else
    begin
      load_cnt_r <= loaded_r ? load_cnt_r : load_cnt_r + 2'h1;
      if (wr_evt && hit_uv)
      begin
        uv_w_r <= xf.wdata;
        uv_lim_r <= wv[15:0];
      end
      if (wr_evt && hit_dly)
      begin
        dly_w_r <= xf.wdata;
        dly_h_r <= clip8(wv >>> 7);
      end
      if (wr_evt && hit_rise)
      begin
        rise_w_r <= xf.wdata;
        rise_q_r <= clip8(wv >>> 6) > 8'h7F ? 7'h7F : rise_nq_w(wv);
      end
      if (wr_evt && hit_tmo)
      begin
        tmo_w_r <= xf.wdata;
        tmo_h_r <= clip8(wv >>> 7);
      end
    end
  end

  function automatic logic [6:0] rise_nq_w(input logic signed [31:0] v);
    logic [7:0] q;
    q = clip8(v >>> 6);
    rise_nq_w = q[6:0];
  endfunction: rise_nq_w

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      init_cnt_r <= 14'h0000;
      init_done_r <= 1'b0;
    end
    else if (!init_done_r)
    begin
      init_cnt_r <= init_cnt_r + 14'h0001;
      init_done_r <= init_cnt_r == 14'(INIT_CYCLES - 1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= S_OFF;
      ph_cnt_r <= 10'h000;
      tmo_run_r <= 1'b0;
      tmo_cnt_r <= 10'h000;
      vin_last_r <= 16'h0000;
      vout_last_r <= 16'h0000;
      st_r <= 8'h00;
      alert_n <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      ph_cnt_r <= (state_nxt != state_r) ? 10'h000 : ph_cnt_r + {9'h000, tick};
      tmo_run_r <= rise_start || (tmo_run_r && !reached && !tmo_expire && start_s);
      tmo_cnt_r <= rise_start ? 10'h000 : tmo_cnt_r + {9'h000, tick & tmo_run_r};
      vin_last_r <= power_input_supply_valid ? power_input_supply_tlm : vin_last_r;
      vout_last_r <= vout_tlm_valid ? vout_tlm : vout_last_r;
      st_r <= st_nxt;
      alert_n <= ~|st_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      power_stage_en <= 1'b0;
      ref_ramp_en <= 1'b0;
      uv_check_en <= 1'b0;
      rise_quarters <= `RISE_MIN_Q;
      ton_max_fault <= 1'b0;
    end
    else
    begin
      power_stage_en <= (state_nxt == S_RISE) || (state_nxt == S_ON) || (state_nxt == S_FWAIT);
      ref_ramp_en <= state_nxt == S_RISE;
      uv_check_en <= (state_nxt == S_ON) || (state_nxt == S_FWAIT);
      rise_quarters <= rise_eff;
      ton_max_fault <= tmo_evt;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_uv_flags_set: assert property (uv_evt |=> st_r[`ST_UVW] && st_r[`ST_INPUT] && st_r[`ST_NOTA] && !alert_n)
    else $error("warning flags not raised");
  a_uv_floor_kept: assert property (loaded_r && wr_evt && hit_uv |=> uv_lim_r >= 16'h0500 && uv_lim_r <= 16'h1600)
    else $error("warning limit out of range");
  a_uv_low_reject: assert property (loaded_r && req_evt && xf.wr && hit_uv && wv < `UV_MIN
    |=> $stable(uv_w_r) && st_r[`ST_CML_DATA])
    else $error("low warning limit accepted");
  a_bad_data_flag: assert property (bad_data |=> st_r[`ST_CML_DATA] && !alert_n)
    else $error("invalid data not flagged");
  a_delay_honoured: assert property (rise_start |-> ph_cnt_r >= dly_ticks && init_done_r)
    else $error("rise started before delay");
  a_init_wait: assert property ($rose(init_done_r) |-> $past(init_cnt_r) == 14'(INIT_CYCLES - 1))
    else $error("initialisation wait wrong");
  a_rise_floor: assert property (state_r == S_RISE && state_nxt == S_ON |-> ph_cnt_r >= 10'h002)
    else $error("rise shorter than half ms");
  a_uv_check_gate: assert property (uv_check_en |-> state_r != S_RISE && state_r != S_DELAY)
    else $error("undervoltage check during rise");
  a_tmo_disabled: assert property (tmo_h_r == 8'h00 |-> !tmo_evt)
    else $error("timeout with zero limit");
  a_tmo_immediate: assert property (tmo_evt && start_s && timeout_response_code == 2'h2 |=> state_r == S_SHUT)
    else $error("immediate shutdown missed");
  a_tmo_flags_set: assert property (tmo_evt |=> st_r[`ST_TONMAX] && st_r[`ST_VOUT] && ton_max_fault)
    else $error("timeout flags not raised");
endmodule: stcmd_top
`default_nettype wire

// *** tb/stcmd_host_model.sv ***
// host controller model issuing word commands on the link clock
`timescale 1ns/1ps
`default_nettype none
module stcmd_host_model (
  input wire logic link_clock,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
      output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    n = 0;
    @(posedge link_clock);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= wd;
    do
    begin
      @(posedge link_clock);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 40);
    // released code and data lines scrambled so stale values cannot pass
    cmd_valid <= 1'b0;
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
    do
    begin
      @(posedge link_clock);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 80);
    if (rsp_valid === 1'b1)
    begin
      rd = rsp_data;
      ok = 1'b1;
    end
  endtask: xfer
endmodule: stcmd_host_model
`default_nettype wire

// *** tb/testbench.sv ***
// testbench for the start-up timing and warning command block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] code; logic [15:0] wd; logic [15:0] rb; logic [1:0] ef;} stcmd_case_t;
  localparam stcmd_case_t CASES [11] = '{
    '{8'h58, 16'hF014, 16'hF014, 2'h0}, '{8'h58, 16'hF058, 16'hF058, 2'h0},
    '{8'h58, 16'hF059, 16'hF058, 2'h1}, '{8'h58, 16'hF013, 16'hF058, 2'h1},
    '{8'h60, 16'hF8FF, 16'hF8FF, 2'h0}, '{8'h60, 16'hF900, 16'hF8FF, 2'h1},
    '{8'h61, 16'hF07F, 16'hF07F, 2'h0}, '{8'h61, 16'hF080, 16'hF07F, 2'h1},
    '{8'h62, 16'hF8FE, 16'hF8FE, 2'h0}, '{8'h62, 16'hF8FF, 16'hF8FE, 2'h1},
    '{8'h59, 16'h1234, 16'h0000, 2'h2}};
  logic clock, rst, link_clock, link_rst, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data, rd;
  logic on_start_pin = 1'b0, clear_faults = 1'b0;
  logic [15:0] vin = 16'h1800, vout_tlm = 16'h0000;
  logic [1:0] resp = 2'h0;
  logic strap_sel = 1'b1, nvm_ok = 1'b1, vin_ok = 1'b1, vo_ok = 1'b1;
  logic [6:0] strap_q = 7'h08;
  logic [10:0] uv_man = 11'h00A;
  logic [15:0] vcmd = 16'h1000;
  logic [2:0] fdly = 3'h1;
  logic uvw, st_in, st_vo, st_nota, st_cml, st_ton, st_cd, st_cc, alert_n, pwr_en, ramp_en, uv_en, fault;
  logic [6:0] rise_q;
  wire [3:0] watch = {fault, uv_en, ramp_en, pwr_en};
  int miscompares = 0;
  int n_compared = 0;
  stcmd_top #(.TICK_CYCLES(20), .INIT_CYCLES(8)) u_stcmd_top (.clock(clock), .rst(rst),
    .link_clock(link_clock), .link_rst(link_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .on_start_pin(on_start_pin), .strap_rise_sel_pin(strap_sel), .strap_rise_pin(strap_q),
    .nvm_valid(nvm_ok), .nvm_uv_man(uv_man), .nvm_dly_man(11'h004), .nvm_rise_man(11'h00C),
    .nvm_tmo_man(11'h008), .power_input_supply_tlm(vin), .power_input_supply_valid(vin_ok),
    .vout_tlm(vout_tlm), .vout_tlm_valid(vo_ok), .vout_cmd(vcmd), .timeout_response_code(resp),
    .timeout_delay_ms(fdly), .clear_faults(clear_faults), .input_uv_warning_flag(uvw),
    .status_input_summary(st_in), .status_vout_summary(st_vo), .status_none_above(st_nota),
    .status_cml_summary(st_cml), .status_ton_max(st_ton), .status_cml_data(st_cd), .status_cml_cmd(st_cc),
    .alert_n(alert_n), .power_stage_en(pwr_en), .ref_ramp_en(ramp_en), .rise_quarters(rise_q),
    .uv_check_en(uv_en), .ton_max_fault(fault));
  stcmd_host_model u_stcmd_host_model (.link_clock(link_clock), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask: check
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask: wrap_up
  task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    logic ok;
    u_stcmd_host_model.xfer(wr, code, wd, rd, ok);
    if (ok !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
  endtask: acc
  task automatic wait_on(input int idx, output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (watch[idx] !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      miscompares++;
      wrap_up();
    end
  endtask: wait_on
  task automatic clr();
    @(posedge clock);
    clear_faults <= 1'b1;
    @(posedge clock);
    clear_faults <= 1'b0;
    repeat (3) @(posedge clock);
  endtask: clr
  // link side leaves reset first so no stale toggle reaches the core
  task automatic reboot(input logic nv, input logic sel);
    @(posedge clock);
    rst <= 1'b1;
    link_rst <= 1'b1;
    nvm_ok <= nv;
    strap_sel <= sel;
    repeat (3) @(posedge link_clock);
    link_rst <= 1'b0;
    @(posedge clock);
    rst <= 1'b0;
  endtask: reboot
  // low telemetry must trip the timeout when f_exp is set; each response code handled
  task automatic run_start(input logic [1:0] code, input logic [15:0] vo, input logic f_exp);
    int n;
    int m;
    @(posedge clock);
    resp <= code;
    vout_tlm <= vo;
    on_start_pin <= 1'b1;
    wait_on(0, n);
    check(16'(n > 60 && n < 110), 16'h0001);
    wait_on(2, m);
    check(16'(m > 18 && m < 46 && ramp_en === 1'b0), 16'h0001);
    if (f_exp)
    begin
      wait_on(3, n);
      check(16'(n + m > 58 && n + m < 106), 16'h0001);
      repeat (3) @(posedge clock);
      check(16'({st_ton, st_vo, st_nota, alert_n}), 16'h000E);
      check(16'(pwr_en), 16'(!code[1]));
      repeat (120) @(posedge clock);
      check(16'(pwr_en), 16'(code == 2'h0));
    end
    else
    begin
      repeat (200) @(posedge clock);
      check(16'({st_ton, pwr_en}), 16'h0001);
    end
    on_start_pin <= 1'b0;
    clr();
  endtask: run_start
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    link_clock = 1'b0;
    #37;
    forever #80 link_clock = ~link_clock;
  end
  initial
  begin
    repeat (100000) @(posedge clock);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    rst = 1'b1;
    link_rst = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge link_clock);
    link_rst <= 1'b0;
    clr();
    acc(1'b0, 8'h58, 16'h0000);
    check(rd, 16'hF00A);
    acc(1'b0, 8'h60, 16'h0000);
    check(rd, 16'hF804);
    acc(1'b0, 8'h61, 16'h0000);
    check(rd, 16'hF008);
    acc(1'b0, 8'h62, 16'h0000);
    check(rd, 16'hF808);
    check(16'(rise_q), 16'h0008);
    for (int i = 0; i < 11; i++)
    begin
      acc(1'b1, CASES[i].code, CASES[i].wd);
      check(16'({st_cc, st_cd}), 16'(CASES[i].ef));
      check(16'(alert_n), 16'(CASES[i].ef == 2'h0));
      acc(1'b0, CASES[i].code, 16'h0000);
      check(rd, CASES[i].rb);
      clr();
    end
    // limit now 22 V, supply at 20 V warns
    @(posedge clock);
    vin_ok <= 1'b0;
    vin <= 16'h1400;
    repeat (4) @(posedge clock);
    check(16'({uvw, alert_n}), 16'h0001);
    vin_ok <= 1'b1;
    repeat (4) @(posedge clock);
    check(16'({uvw, st_in, st_nota, alert_n}), 16'h000E);
    vin <= 16'h1800;
    clr();
    check(16'({uvw, alert_n}), 16'h0001);
    acc(1'b1, 8'h60, 16'hF802);
    acc(1'b1, 8'h61, 16'hF001);
    acc(1'b1, 8'h62, 16'hF802);
    check(16'(rise_q), 16'h0002);
    for (int c = 0; c < 4; c++)
      run_start(2'(c), 16'h0000, 1'b1);
    run_start(2'h2, 16'h0F00, 1'b0);
    acc(1'b1, 8'h62, 16'hF800);
    run_start(2'h2, 16'h0000, 1'b0);
    // no memory image: limit falls back to its default, rise from straps
    uv_man <= 11'h018;
    strap_q <= 7'h05;
    reboot(1'b0, 1'b1);
    acc(1'b0, 8'h58, 16'h0000);
    check(rd, 16'hF00A);
    acc(1'b0, 8'h61, 16'h0000);
    check(rd, 16'hF005);
    check(16'({rise_q, pwr_en, alert_n}), 16'h0015);
    reboot(1'b1, 1'b0);
    acc(1'b0, 8'h58, 16'h0000);
    check(rd, 16'hF018);
    acc(1'b0, 8'h61, 16'h0000);
    check(rd, 16'hF00C);
    wrap_up();
  end
endmodule: testbench
`default_nettype wire
